// >>> hdl/cotc_pkg.sv
// Constants shared by the constant off-time chopper block
package cotc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CONF = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // Configuration register field positions
  localparam int CONF_OFF_LSB = 0;
  localparam int CONF_START_LSB = 4;
  localparam int CONF_END_LSB = 7;
  localparam int CONF_FD_HI_BIT = 11;
  localparam int CONF_FD_CMP_OFF_BIT = 12;
  localparam int CONF_RAND_OFF_BIT = 13;
  localparam int CONF_MODE_BIT = 14;
  localparam int CONF_SYNC_LSB = 16;
  localparam logic [31:0] CONF_RESET = 32'h0000_4003;
  // Target register: bits 8:0 are the sine target magnitude
  localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
  // Off time basis: 12 + 32 * setting system clocks
  localparam int OFF_BASE = 12;
  localparam int OFF_STEP = 32;
  localparam int SYNC_UNIT = 64;
  localparam int FD_STEP = 32;
  localparam logic [3:0] OFFSET_ZERO = 4'h3;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // Chopper phase encoding
  typedef enum logic [1:0] {
    PH_ON = 2'b00,
    PH_FAST = 2'b01,
    PH_SLOW = 2'b10,
    PH_WAIT = 2'b11
  } cotc_phase_t;
endpackage : cotc_pkg

// >>> hdl/cotc_coil.sv
// One coil chopper: on, fast decay, slow decay, optional wait for sync
`timescale 1ns/1ns
module cotc_coil (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_const_off,
  input wire logic i_comp_trip,
  input wire logic i_comp_neg,
  input wire logic i_fd_dis_comp,
  input wire logic [9:0] i_fast_ticks,
  input wire logic [9:0] i_slow_ticks,
  input wire logic i_sync_on,
  input wire logic i_sync_pulse,
  output logic [1:0] o_phase
);
  cotc_pkg::cotc_phase_t phase_reg;
  logic [9:0] count_reg;

  always_ff @(posedge i_clock) begin
    if (i_rst || !i_enable) begin
      phase_reg <= cotc_pkg::PH_ON;
      count_reg <= 10'h000;
    end else begin
      unique case (phase_reg)
        cotc_pkg::PH_ON: begin
          if (i_comp_trip) begin // R3
            count_reg <= 10'h000;
            if (i_const_off && i_fast_ticks != 10'h000) begin
              phase_reg <= cotc_pkg::PH_FAST; // R4
            end else begin
              phase_reg <= cotc_pkg::PH_SLOW; // R4
            end
          end
        end
        cotc_pkg::PH_FAST: begin
          count_reg <= count_reg + 10'h001;
          if (count_reg + 10'h001 >= i_fast_ticks || (!i_fd_dis_comp && i_comp_neg)) begin // R6
            phase_reg <= cotc_pkg::PH_SLOW;
            count_reg <= 10'h000;
          end
        end
        cotc_pkg::PH_SLOW: begin
          count_reg <= count_reg + 10'h001;
          if (count_reg + 10'h001 >= i_slow_ticks) begin // R14
            count_reg <= 10'h000;
            if (i_sync_on && !i_sync_pulse) begin
              phase_reg <= cotc_pkg::PH_WAIT; // R9
            end else begin
              phase_reg <= cotc_pkg::PH_ON;
            end
          end
        end
        cotc_pkg::PH_WAIT: begin
          if (i_sync_pulse || !i_sync_on) begin // R15
            phase_reg <= cotc_pkg::PH_ON;
          end
        end
      endcase
    end
  end

  assign o_phase = phase_reg;
endmodule : cotc_coil

// >>> hdl/cotc_top.sv
// Two-coil constant off-time chopper control with APB registers
// Function
// [R1] Mode bit 0 selects hysteresis chopper, 1 selects constant off-time chopper.
// [R2] Full-step load-dependent speed mode forces constant off-time chopper.
// [R3] On phase until comparator trips, then fixed fast decay, then slow decay.
// [R4] Fast decay time from high bit plus start field; zero means slow only.
// [R5] End field adds offset to target: codes 0-2 negative, 3 none, 4-15 positive.
// [R6] Comparator bit 0 ends fast decay early on negative current; 1 time only.
// [R7] Without sync, both coil choppers run independently.
// [R8] Random bit modulates slow decay off time via pseudo-random generator.
// [R9] Sync only lengthens off time to next sync pulse, never shortens.
// [R10] Sync field 0 disables; 1-15 gives period field times 64 clocks.
// [R11] Sync switches off while velocity exceeds high velocity threshold.
// [R12] Sync has no effect while voltage-mode quiet chopper is active.
// [R13] Software should set sync for twice or base chopper frequency, short off time.
// [R14] Slow decay off time is 12 plus 32 times the setting in clocks.
// [R15] Divider and counters on system clock; on phase starts at first sync after off.
// [R16] Free-running LFSR low bits add a few clocks to slow decay.
`timescale 1ns/1ns
module cotc_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_fullstep_speed_mode,
  input wire logic i_above_high_velocity,
  input wire logic i_quiet_chopper,
  input wire logic [1:0] i_comp_trip,
  input wire logic [1:0] i_comp_neg,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic [1:0] o_bridge_on,
  output logic [1:0] o_bridge_fast,
  output logic o_const_off_active,
  output logic o_sync_active,
  output logic [9:0] o_target_current
);
  logic [31:0] conf_reg;
  logic [8:0] target_reg;
  logic [15:0] lfsr_reg;
  logic [9:0] sync_cnt_reg;
  logic sync_pulse_reg;
  logic [3:0] slow_decay_off_time;
  logic [3:0] fast_decay_time;
  logic [3:0] hysteresis_end_field;
  logic [3:0] sync_div;
  logic const_off;
  logic sync_on;
  logic [9:0] sync_period;
  logic [9:0] fast_ticks;
  logic [9:0] slow_base;
  logic [9:0] slow_ticks;
  logic [1:0] ph0;
  logic [1:0] ph1;
  logic access;
  logic mapped;
  logic [10:0] offs_sum;

  assign access = i_psel && i_penable;
  assign mapped = i_paddr == cotc_pkg::ADDR_CONF || i_paddr == cotc_pkg::ADDR_TARGET ||
                  i_paddr == cotc_pkg::ADDR_STATUS;
  assign slow_decay_off_time = conf_reg[cotc_pkg::CONF_OFF_LSB +: 4];
  assign fast_decay_time = {conf_reg[cotc_pkg::CONF_FD_HI_BIT], conf_reg[cotc_pkg::CONF_START_LSB +: 3]}; // R4
  assign hysteresis_end_field = conf_reg[cotc_pkg::CONF_END_LSB +: 4];
  assign sync_div = conf_reg[cotc_pkg::CONF_SYNC_LSB +: 4];
  assign const_off = conf_reg[cotc_pkg::CONF_MODE_BIT] || i_fullstep_speed_mode; // R1 R2
  assign sync_on = sync_div != 4'h0 && !i_above_high_velocity && !i_quiet_chopper; // R10 R11 R12
  assign sync_period = 10'(sync_div) * 10'(cotc_pkg::SYNC_UNIT); // R10
  assign fast_ticks = 10'(fast_decay_time) * 10'(cotc_pkg::FD_STEP);
  assign slow_base = 10'(cotc_pkg::OFF_BASE) + 10'(slow_decay_off_time) * 10'(cotc_pkg::OFF_STEP); // R14
  assign slow_ticks = conf_reg[cotc_pkg::CONF_RAND_OFF_BIT] ? slow_base + 10'(lfsr_reg[2:0]) : slow_base; // R8 R16
  // Offset of code minus three, applied to target magnitude
  assign offs_sum = 11'(target_reg) + 11'(hysteresis_end_field) - 11'(cotc_pkg::OFFSET_ZERO); // R5

  // Register writes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      conf_reg <= cotc_pkg::CONF_RESET;
      target_reg <= cotc_pkg::TARGET_RESET[8:0];
    end else if (access && i_pwrite && o_pready) begin
      if (i_paddr == cotc_pkg::ADDR_CONF) begin
        conf_reg <= {12'h000, i_pwdata[19:16], 1'b0, i_pwdata[14:0]};
      end
      if (i_paddr == cotc_pkg::ADDR_TARGET) begin
        target_reg <= i_pwdata[8:0];
      end
    end
  end

  // APB answer: one wait state, pready on second access cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= access && !o_pready;
      o_pslverr <= access && !o_pready && !mapped;
      if (access && !o_pready && !i_pwrite) begin
        unique case (i_paddr)
          cotc_pkg::ADDR_CONF: o_prdata <= conf_reg;
          cotc_pkg::ADDR_TARGET: o_prdata <= {23'h000000, target_reg};
          cotc_pkg::ADDR_STATUS: o_prdata <= {26'h0000000, sync_on, const_off, ph1, ph0};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Free-running pseudo-random generator
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lfsr_reg <= cotc_pkg::LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]}; // R16
    end
  end

  // Common sync clock divider
  always_ff @(posedge i_clock) begin
    if (i_rst || sync_div == 4'h0) begin
      sync_cnt_reg <= 10'h000;
      sync_pulse_reg <= 1'b0;
    end else if (sync_cnt_reg + 10'h001 >= sync_period) begin
      sync_cnt_reg <= 10'h000; // R15
      sync_pulse_reg <= 1'b1;
    end else begin
      sync_cnt_reg <= sync_cnt_reg + 10'h001;
      sync_pulse_reg <= 1'b0;
    end
  end

  // Independent coil choppers, sharing only the optional sync pulse
  cotc_coil u_coil_a ( // R7
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(1'b1),
    .i_const_off(const_off),
    .i_comp_trip(i_comp_trip[0]),
    .i_comp_neg(i_comp_neg[0]),
    .i_fd_dis_comp(conf_reg[cotc_pkg::CONF_FD_CMP_OFF_BIT]),
    .i_fast_ticks(fast_ticks),
    .i_slow_ticks(slow_ticks),
    .i_sync_on(sync_on),
    .i_sync_pulse(sync_pulse_reg),
    .o_phase(ph0)
  );
  cotc_coil u_coil_b (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(1'b1),
    .i_const_off(const_off),
    .i_comp_trip(i_comp_trip[1]),
    .i_comp_neg(i_comp_neg[1]),
    .i_fd_dis_comp(conf_reg[cotc_pkg::CONF_FD_CMP_OFF_BIT]),
    .i_fast_ticks(fast_ticks),
    .i_slow_ticks(slow_ticks),
    .i_sync_on(sync_on),
    .i_sync_pulse(sync_pulse_reg),
    .o_phase(ph1)
  );

  // Registered outputs
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_bridge_on <= 2'b00;
      o_bridge_fast <= 2'b00;
      o_const_off_active <= 1'b0;
      o_sync_active <= 1'b0;
      o_target_current <= 10'h000;
    end else begin
      o_bridge_on <= {ph1 == 2'(cotc_pkg::PH_ON), ph0 == 2'(cotc_pkg::PH_ON)};
      o_bridge_fast <= {ph1 == 2'(cotc_pkg::PH_FAST), ph0 == 2'(cotc_pkg::PH_FAST)};
      o_const_off_active <= const_off;
      o_sync_active <= sync_on;
      if (!const_off) begin
        o_target_current <= {1'b0, target_reg};
      end else if (offs_sum[10]) begin
        o_target_current <= 10'h000;
      end else begin
        o_target_current <= offs_sum[9:0]; // R5
      end
    end
  end
endmodule : cotc_top

// >>> sim/cotc_chk.sv
// Port checker for the chopper block
`timescale 1ns/1ns
module cotc_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_fullstep_speed_mode,
  input wire logic i_above_high_velocity,
  input wire logic i_quiet_chopper,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [1:0] o_bridge_on,
  input wire logic [1:0] o_bridge_fast,
  input wire logic o_const_off_active,
  input wire logic o_sync_active
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [11:0] idle_reg;
  logic seen_reg;
  // Idle cycles of coil A since last drive
  always_ff @(posedge i_clock) begin
    idle_reg <= (i_rst | o_bridge_on[0] | o_bridge_fast[0]) ? 12'h000 : idle_reg + 12'h001;
  end
  always_ff @(posedge i_clock) begin
    seen_reg <= !i_rst && (seen_reg || o_bridge_fast[0]);
  end
  chk_pready_pulse: assert property (o_pready |=> !o_pready) else $error("pready too long");
  chk_pready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("pready late");
  chk_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
  chk_fullstep_mode: assert property (i_fullstep_speed_mode |=> o_const_off_active) else $error("no forced mode");
  chk_velocity_sync: assert property (i_above_high_velocity |=> !o_sync_active) else $error("sync above limit");
  chk_quiet_sync: assert property (i_quiet_chopper |=> !o_sync_active) else $error("sync in quiet mode");
  chk_phase_excl: assert property ((o_bridge_on & o_bridge_fast) == 2'b00) else $error("on and fast");
  chk_fast_after_on: assert property ($rose(o_bridge_fast[0]) |-> $past(o_bridge_on[0])) else $error("fast order");
  chk_slow_min: assert property ($rose(o_bridge_on[0]) && seen_reg |-> idle_reg >= 12'h00C) else $error("off short");
endmodule : cotc_chk
bind cotc_top cotc_chk cotc_chk_i (.i_clock, .i_rst, .i_psel, .i_penable, .i_fullstep_speed_mode,
  .i_above_high_velocity, .i_quiet_chopper, .o_pready, .o_pslverr, .o_bridge_on, .o_bridge_fast,
  .o_const_off_active, .o_sync_active);

// >>> sim/cotc_bridge_model.sv
// Coil bridge and current comparator model
`timescale 1ns/1ns
module cotc_bridge_model #(parameter int ON_T = 3) (
  input wire logic i_clock,
  input wire logic i_on,
  input wire logic i_fast,
  output logic o_trip,
  output logic o_neg
);
  int c = 0;
  logic trip_reg = 1'b0;
  logic neg_reg = 1'b0;
  // Current rises while driven, swings negative in fast decay
  always @(posedge i_clock) begin
    c <= i_on ? c + 1 : 0;
    trip_reg <= i_on && c >= ON_T;
    neg_reg <= i_fast && !neg_reg;
  end
  assign o_trip = trip_reg;
  assign o_neg = neg_reg;
endmodule : cotc_bridge_model

// >>> sim/tb_top.sv
// Self-checking bench for the chopper block
`timescale 1ns/1ns
module tb_top;
  logic i_clock = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, fsm = 0, ahv = 0, qc = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, prd;
  logic pready, perr, coa, sya;
  logic [1:0] on, fast, trip, neg;
  logic [9:0] tc;
  logic [64:0] q[$];
  logic [15:0] r = 16'h8D2B;
  int mismatches = 0, n_compared = 0, cyc = 0, f, s, t0, t1, v, tg;
  always #25 i_clock = ~i_clock;
  always @(posedge i_clock) cyc <= cyc + 1;
  cotc_top cotc_top_i (.i_clock, .i_rst, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .i_fullstep_speed_mode(fsm), .i_above_high_velocity(ahv), .i_quiet_chopper(qc),
    .i_comp_trip(trip), .i_comp_neg(neg), .o_pready(pready), .o_prdata(prd), .o_pslverr(perr),
    .o_bridge_on(on), .o_bridge_fast(fast), .o_const_off_active(coa), .o_sync_active(sya),
    .o_target_current(tc));
  cotc_bridge_model #(.ON_T(3)) cotc_bridge_model_i (.i_clock, .i_on(on[0]), .i_fast(fast[0]),
    .o_trip(trip[0]), .o_neg(neg[0]));
  cotc_bridge_model #(.ON_T(9)) cotc_bridge_model_i2 (.i_clock, .i_on(on[1]), .i_fast(fast[1]),
    .o_trip(trip[1]), .o_neg(neg[1]));
  function logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lf
  function logic [31:0] cf(input int off, hs, en, dis, rnd, mode, sy);
    return 32'((sy << 16) | (mode << 14) | (rnd << 13) | (dis << 12) | (en << 7) | (hs << 4) | off);
  endfunction : cf
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Mask selects the read data bits that are compared
  task rd(input logic [7:0] a, input logic [31:0] e, input logic er, input logic [31:0] m);
    q.push_back({m, er, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // Lengths of one fast and one slow phase of coil A
  task meas();
    f = 0;
    s = 0;
    while (on[0] !== 1'b1) @(negedge i_clock);
    while (on[0] === 1'b1) @(negedge i_clock);
    while (fast[0] === 1'b1) begin
      f++;
      @(negedge i_clock);
    end
    while (on[0] !== 1'b1) begin
      s++;
      @(negedge i_clock);
    end
  endtask : meas
  task cfg(input logic [31:0] d);
    apb(1'b1, 8'h00, d);
    meas();
    meas();
  endtask : cfg
  task rise(output int t);
    while (on[0] === 1'b1) @(negedge i_clock);
    while (on[0] !== 1'b1) @(negedge i_clock);
    t = cyc;
  endtask : rise
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  always @(posedge i_clock) begin : mon
    logic [64:0] e;
    if (pready === 1'b1 && !pwr && q.size() > 0) begin
      e = q.pop_front();
      cmp("prdata", e[31:0] & e[64:33], prd & e[64:33]);
      cmp("pslverr", 32'(e[32]), 32'(perr));
    end
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(8'h00, 32'h0000_4003, 1'b0, 32'hFFFF_FFFF);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000, 1'b1, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_0000, 1'b0, 32'hFFFF_FFFF);
    cfg(cf(1, 1, 3, 1, 0, 1, 0));
    cmp("fast", 32, f);
    cmp("slow", 44, s);
    cfg(cf(1, 1, 3, 0, 0, 1, 0));
    cmp("fast_cut", 1, f < 32);
    cfg(cf(1, 0, 3, 1, 0, 1, 0));
    cmp("no_fast", 0, f);
    cfg(cf(1, 1, 3, 1, 1, 1, 0));
    cmp("rnd", 1, s >= 44 && s <= 51);
    v = 0;
    repeat (4) begin
      meas();
      v += (s != 44);
    end
    cmp("rnd_spread", 1, v > 0);
    cfg(cf(0, 1, 3, 1, 0, 1, 1));
    rise(t0);
    rise(t1);
    cmp("sync", 0, (t1 - t0) % 64);
    cmp("sync_on", 1, sya);
    rd(8'h00, cf(0, 1, 3, 1, 0, 1, 1), 1'b0, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0000_0030, 1'b0, 32'hFFFF_FFF0);
    ahv <= 1'b1;
    repeat (3) @(negedge i_clock);
    cmp("sync_hv", 0, sya);
    @(posedge i_clock);
    ahv <= 1'b0;
    qc <= 1'b1;
    repeat (3) @(negedge i_clock);
    cmp("sync_quiet", 0, sya);
    @(posedge i_clock);
    qc <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      r = lf(r);
      tg = k ? r[8:0] : 1;
      apb(1'b1, 8'h04, tg);
      apb(1'b1, 8'h00, cf(1, 1, k, 1, 0, 1, 0));
      repeat (3) @(negedge i_clock);
      v = tg + k - 3;
      cmp("target", v < 0 ? 0 : v, tc);
    end
    cfg(cf(1, 1, 3, 1, 0, 0, 0));
    cmp("mode", 0, coa);
    cmp("raw", tg, tc);
    cmp("hyst_fast", 0, f);
    @(posedge i_clock);
    fsm <= 1'b1;
    repeat (3) @(negedge i_clock);
    cmp("forced", 1, coa);
    summarize();
  end
endmodule : tb_top
